// File: inc/cps_cfg.svh
`ifndef CPS_CFG_SVH
`define CPS_CFG_SVH
// Clock and timing figures
`define CPS_CLK_MHZ 250
`define CPS_T_BIAS_DLY_MS 220
`define CPS_T_QUAL_MS 30
`define CPS_T_RETRY_MS 2000
`define CPS_T_OVLD_US 256
`define CPS_T_INT_US 256
// Register byte offsets
`define CPS_OFF_CTRL 32'h0000_0000
`define CPS_OFF_ILIM 32'h0000_0004
`define CPS_OFF_VTRK 32'h0000_0008
`define CPS_OFF_STAT 32'h0000_000C
// Control register fields
`define CPS_CTRL_HV_EN 0
`define CPS_CTRL_EN12 1
`define CPS_CTRL_CHG 2
`define CPS_CTRL_BSD 3
// Status register fields
`define CPS_STAT_IG 0
`define CPS_STAT_PG 1
`define CPS_STAT_SRC_LO 2
`define CPS_STAT_BSD 5
// Reset values
`define CPS_CTRL_DEF 4'h5
`define CPS_ILIM_DEF 5'h04
`define CPS_VTRK_DEF 8'hC8
// Current limit codes, 100 mA steps from 100 mA
`define CPS_ILIM_200MA 5'h01
`define CPS_ILIM_500MA 5'h04
`define CPS_ILIM_1A 5'h09
`define CPS_ILIM_2A 5'h13
`define CPS_ILIM_2A1 5'h14
`define CPS_ILIM_2A4 5'h17
// Input voltage limit window in mV
`define CPS_VLIM_MIN 14'h0F3C
`define CPS_VLIM_MAX 14'h1518
`endif

// File: inc/cps_pkg.sv
package cps_pkg;
    typedef enum logic [2:0] {
        CPS_SRC_NONE,
        CPS_SRC_SDP,
        CPS_SRC_DCP,
        CPS_SRC_UNKNOWN,
        CPS_SRC_DIVIDER
    } cps_src_t;
    // D+/D- window comparator result
    typedef enum logic [1:0] {
        CPS_WIN_NONE,
        CPS_WIN_1P2,
        CPS_WIN_2P0,
        CPS_WIN_2P7
    } cps_win_t;
    typedef enum {
        CPS_ST_HIZ,
        CPS_ST_DELAY,
        CPS_ST_QUAL,
        CPS_ST_RETRY,
        CPS_ST_DETECT,
        CPS_ST_HV,
        CPS_ST_VLIM,
        CPS_ST_RUN
    } cps_state_t;
endpackage : cps_pkg

// File: rtl/cps_int_pulse.sv
`timescale 1ns/1ns
module cps_int_pulse #(
    parameter int PULSE_CYC = 64000
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_event,
    output logic o_int_n_o,
    output logic o_int_n_oe
);
    logic [31:0] cnt_reg;
    logic pend_reg;
    logic busy;
    assign busy = (cnt_reg != 32'h0000_0000);
    assign o_int_n_o = 1'b0;

    generate
        if (PULSE_CYC < 2) begin : g_bad
            $error("cps_int_pulse: pulse too short");
        end
    endgenerate

    // Events during a pulse wait for it to end; several such events merge into one later pulse
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pend_reg <= 1'b0;
        end else if (i_event && busy) begin
            pend_reg <= 1'b1;
        end else if (!busy) begin
            pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_reg <= 32'h0000_0000;
            o_int_n_oe <= 1'b0;
        end else if (busy) begin
            cnt_reg <= cnt_reg - 32'h0000_0001;
            o_int_n_oe <= (cnt_reg != 32'h0000_0001);
        end else if (i_event || pend_reg) begin
            cnt_reg <= 32'(PULSE_CYC);
            o_int_n_oe <= 1'b1;
        end
    end
endmodule : cps_int_pulse

// File: rtl/cps_top.sv
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ns
`include "cps_cfg.svh"
module cps_top #(
    parameter int BIAS_DLY_CYC = `CPS_T_BIAS_DLY_MS * 1000 * `CPS_CLK_MHZ,
    parameter int QUAL_CYC = `CPS_T_QUAL_MS * 1000 * `CPS_CLK_MHZ,
    parameter int RETRY_CYC = `CPS_T_RETRY_MS * 1000 * `CPS_CLK_MHZ,
    parameter int OVLD_CYC = `CPS_T_OVLD_US * `CPS_CLK_MHZ,
    parameter int INT_CYC = `CPS_T_INT_US * `CPS_CLK_MHZ
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_vac_above_uvlo,
    input wire logic i_bat_above_uvlo,
    input wire logic i_vac_present,
    input wire logic i_vac_above_sleepz,
    input wire logic i_boost_mode,
    input wire logic i_vbus_below_sleep,
    input wire logic i_bat_above_dpl,
    input wire logic i_bat_overload,
    input wire logic i_vbus_ov,
    input wire logic i_vbus_above_min,
    input wire logic i_bc_done,
    input wire logic i_bc_sdp,
    input wire logic i_bc_dcp,
    input wire logic i_dcd_timeout,
    input wire logic [1:0] i_dp_win,
    input wire logic [1:0] i_dm_win,
    input wire logic i_hv_done,
    input wire logic i_sys_above_2p2,
    input wire logic [13:0] i_vbat_mv,
    output logic o_bias_reg_en,
    output logic o_hiz,
    output logic o_test_sink_en,
    output logic o_bc_start,
    output logic o_hv_req_9v,
    output logic o_hv_req_12v,
    output logic o_conv_en,
    output logic o_batt_switch_on,
    output logic [4:0] o_ilim_eff,
    output logic [13:0] o_vlim_mv,
    output logic o_int_n_o,
    output logic o_int_n_oe
);
    cps_pkg::cps_state_t state_reg;
    logic [31:0] tmr_reg;
    logic [31:0] ovld_reg;
    logic [3:0] ctrl_reg;
    logic [4:0] ilim_reg;
    logic [7:0] vtrk_reg;
    logic ig_reg;
    logic pg_reg;
    logic bsd_reg;
    cps_pkg::cps_src_t src_reg;
    logic supply_prev_reg;
    logic vac_prev_reg;
    logic int_ev_reg;
    logic por_evt;
    logic vac_rise;
    logic bias_ok;
    logic qual_bad;
    logic det_load;
    logic [4:0] det_ilim;
    cps_pkg::cps_src_t det_src;
    logic ovld_hit;
    logic [14:0] vsum;
    logic wr_reg;
    logic [31:0] waddr_reg;
    logic rd_go;
    logic wr_go;

    generate
        if (QUAL_CYC < 1 || RETRY_CYC < 1 || BIAS_DLY_CYC < 1 || OVLD_CYC < 1) begin : g_bad
            $error("cps_top: timing counts must be at least one cycle");
        end
    endgenerate

    // Divider pair to current limit; anything else is an unknown adapter
    function automatic logic [4:0] cps_divider_ilim(input logic [1:0] dp, input logic [1:0] dm);
        if (dp == cps_pkg::CPS_WIN_2P7 && dm == cps_pkg::CPS_WIN_2P0) begin
            return `CPS_ILIM_2A1;
        end else if (dp == cps_pkg::CPS_WIN_1P2 && dm == cps_pkg::CPS_WIN_1P2) begin
            return `CPS_ILIM_2A;
        end else if (dp == cps_pkg::CPS_WIN_2P0 && dm == cps_pkg::CPS_WIN_2P7) begin
            return `CPS_ILIM_1A;
        end else if (dp == cps_pkg::CPS_WIN_2P7 && dm == cps_pkg::CPS_WIN_2P7) begin
            return `CPS_ILIM_2A4;
        end else begin
            return `CPS_ILIM_500MA;
        end
    endfunction : cps_divider_ilim

    // =====================================================
    // Supply events
    // =====================================================
    assign por_evt = (i_vac_above_uvlo || i_bat_above_uvlo) && !supply_prev_reg;
    assign vac_rise = i_vac_present && !vac_prev_reg;

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            supply_prev_reg <= 1'b0;
            vac_prev_reg <= 1'b0;
        end else begin
            supply_prev_reg <= i_vac_above_uvlo || i_bat_above_uvlo;
            vac_prev_reg <= i_vac_present;
        end
    end

    // =====================================================
    // AHB-Lite slave, zero wait states
    // =====================================================
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign rd_go = i_hsel && i_htrans[1] && i_hready && !i_hwrite;
    assign wr_go = wr_reg && (waddr_reg == `CPS_OFF_CTRL);

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_reg <= 1'b0;
            waddr_reg <= 32'h0000_0000;
        end else if (i_hready) begin
            wr_reg <= i_hsel && i_htrans[1] && i_hwrite;
            waddr_reg <= i_haddr;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_hrdata <= 32'h0000_0000;
        end else if (rd_go) begin
            if (i_haddr == `CPS_OFF_CTRL) begin
                o_hrdata <= {28'h000_0000, ctrl_reg[3:1] & 3'h3, ctrl_reg[0]} |
                    {26'h000_0000, bsd_reg, 5'h00} >> 2;
            end else if (i_haddr == `CPS_OFF_ILIM) begin
                o_hrdata <= {27'h000_0000, ilim_reg};
            end else if (i_haddr == `CPS_OFF_VTRK) begin
                o_hrdata <= {24'h00_0000, vtrk_reg};
            end else if (i_haddr == `CPS_OFF_STAT) begin
                o_hrdata <= {26'h000_0000, bsd_reg, src_reg, pg_reg, ig_reg};
            end else begin
                o_hrdata <= 32'h0000_0000;
            end
        end
    end

    // Control bits; the disable bit lives in bsd_reg
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_reg <= `CPS_CTRL_DEF;
        end else if (por_evt) begin
            ctrl_reg <= `CPS_CTRL_DEF;
        end else if (wr_go) begin
            ctrl_reg <= {1'b0, i_hwdata[`CPS_CTRL_CHG:`CPS_CTRL_HV_EN]};
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            vtrk_reg <= `CPS_VTRK_DEF;
        end else if (por_evt) begin
            vtrk_reg <= `CPS_VTRK_DEF;
        end else if (wr_reg && waddr_reg == `CPS_OFF_VTRK) begin
            vtrk_reg <= i_hwdata[7:0];
        end
    end

    // Detection load wins over a host write in the same cycle
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ilim_reg <= `CPS_ILIM_DEF;
        end else if (por_evt) begin
            ilim_reg <= `CPS_ILIM_DEF;
        end else if (det_load) begin
            ilim_reg <= det_ilim;
        end else if (wr_reg && waddr_reg == `CPS_OFF_ILIM) begin
            ilim_reg <= i_hwdata[4:0];
        end
    end

    // =====================================================
    // Battery path overload
    // =====================================================
    assign ovld_hit = i_bat_overload && (ovld_reg == 32'(OVLD_CYC - 1));

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ovld_reg <= 32'h0000_0000;
        end else if (!i_bat_overload || ovld_hit) begin
            ovld_reg <= 32'h0000_0000;
        end else begin
            ovld_reg <= ovld_reg + 32'h0000_0001;
        end
    end

    // Setting wins over a clear by plug-in or by software writing zero
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bsd_reg <= 1'b0;
        end else if (ovld_hit) begin
            bsd_reg <= 1'b1;
        end else if (por_evt || vac_rise) begin
            bsd_reg <= 1'b0;
        end else if (wr_go) begin
            bsd_reg <= i_hwdata[`CPS_CTRL_BSD];
        end
    end

    // =====================================================
    // Power-up sequence
    // =====================================================
    assign bias_ok = i_vac_present && (i_boost_mode ? i_vbus_below_sleep : i_vac_above_sleepz);
    assign qual_bad = i_vbus_ov || !i_vbus_above_min;

    always_comb begin
        det_load = 1'b0;
        det_ilim = `CPS_ILIM_500MA;
        det_src = cps_pkg::CPS_SRC_UNKNOWN;
        if (state_reg == cps_pkg::CPS_ST_DETECT && bias_ok) begin
            if (i_bc_done) begin
                det_load = 1'b1;
                if (i_bc_sdp) begin
                    det_src = cps_pkg::CPS_SRC_SDP;
                end else if (i_bc_dcp) begin
                    det_ilim = `CPS_ILIM_2A4;
                    det_src = cps_pkg::CPS_SRC_DCP;
                end
            end else if (i_dcd_timeout) begin
                det_load = 1'b1;
                det_ilim = cps_divider_ilim(i_dp_win, i_dm_win);
                if (det_ilim != `CPS_ILIM_500MA) begin
                    det_src = cps_pkg::CPS_SRC_DIVIDER;
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= cps_pkg::CPS_ST_HIZ;
            tmr_reg <= 32'h0000_0000;
        end else if (!bias_ok) begin
            state_reg <= cps_pkg::CPS_ST_HIZ;
            tmr_reg <= 32'h0000_0000;
        end else begin
            tmr_reg <= tmr_reg + 32'h0000_0001;
            case (state_reg)
                cps_pkg::CPS_ST_HIZ: begin
                    state_reg <= cps_pkg::CPS_ST_DELAY;
                    tmr_reg <= 32'h0000_0000;
                end
                cps_pkg::CPS_ST_DELAY: begin
                    if (tmr_reg == 32'(BIAS_DLY_CYC - 1)) begin
                        state_reg <= cps_pkg::CPS_ST_QUAL;
                        tmr_reg <= 32'h0000_0000;
                    end
                end
                cps_pkg::CPS_ST_QUAL: begin
                    if (qual_bad) begin
                        state_reg <= cps_pkg::CPS_ST_RETRY;
                        tmr_reg <= 32'h0000_0000;
                    end else if (tmr_reg == 32'(QUAL_CYC - 1)) begin
                        state_reg <= cps_pkg::CPS_ST_DETECT;
                    end
                end
                cps_pkg::CPS_ST_RETRY: begin
                    if (tmr_reg == 32'(RETRY_CYC - 1)) begin
                        state_reg <= cps_pkg::CPS_ST_QUAL;
                        tmr_reg <= 32'h0000_0000;
                    end
                end
                cps_pkg::CPS_ST_DETECT: begin
                    if (det_load) begin
                        state_reg <= (det_src == cps_pkg::CPS_SRC_DCP) ?
                            cps_pkg::CPS_ST_HV : cps_pkg::CPS_ST_VLIM;
                    end
                end
                cps_pkg::CPS_ST_HV: begin
                    if (!ctrl_reg[`CPS_CTRL_HV_EN] || i_hv_done) begin
                        state_reg <= cps_pkg::CPS_ST_VLIM;
                    end
                end
                cps_pkg::CPS_ST_VLIM: begin
                    state_reg <= cps_pkg::CPS_ST_RUN;
                end
                default: begin
                    state_reg <= cps_pkg::CPS_ST_RUN;
                end
            endcase
        end
    end

    // Status flags fall with the input; the pulse is raised with each flag
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ig_reg <= 1'b0;
            pg_reg <= 1'b0;
            src_reg <= cps_pkg::CPS_SRC_NONE;
            int_ev_reg <= 1'b0;
        end else if (por_evt || !bias_ok) begin
            ig_reg <= 1'b0;
            pg_reg <= 1'b0;
            src_reg <= cps_pkg::CPS_SRC_NONE;
            int_ev_reg <= 1'b0;
        end else begin
            int_ev_reg <= 1'b0;
            if (state_reg == cps_pkg::CPS_ST_QUAL && !qual_bad && tmr_reg == 32'(QUAL_CYC - 1)) begin
                ig_reg <= 1'b1;
                int_ev_reg <= 1'b1;
            end
            if (det_load) begin
                pg_reg <= 1'b1;
                src_reg <= det_src;
                int_ev_reg <= 1'b1;
            end
        end
    end

    // =====================================================
    // Outputs
    // =====================================================
    assign o_bias_reg_en = state_reg != cps_pkg::CPS_ST_HIZ && state_reg != cps_pkg::CPS_ST_DELAY;
    assign o_hiz = !o_bias_reg_en;
    assign o_test_sink_en = state_reg == cps_pkg::CPS_ST_QUAL;
    assign o_bc_start = state_reg == cps_pkg::CPS_ST_DETECT;
    assign o_hv_req_9v = state_reg == cps_pkg::CPS_ST_HV && ctrl_reg[`CPS_CTRL_HV_EN] &&
        !ctrl_reg[`CPS_CTRL_EN12];
    assign o_hv_req_12v = state_reg == cps_pkg::CPS_ST_HV && ctrl_reg[`CPS_CTRL_HV_EN] &&
        ctrl_reg[`CPS_CTRL_EN12];
    assign o_conv_en = state_reg == cps_pkg::CPS_ST_RUN;
    // Before the converter runs the battery alone feeds the system
    assign o_batt_switch_on = !bsd_reg &&
        (o_conv_en ? ctrl_reg[`CPS_CTRL_CHG] : i_bat_above_dpl);
    // Soft-start cap only ever lowers the host's setting
    assign o_ilim_eff = (!i_sys_above_2p2 && ilim_reg > `CPS_ILIM_200MA) ?
        `CPS_ILIM_200MA : ilim_reg;

    assign vsum = {1'b0, i_vbat_mv} + {7'h00, vtrk_reg};
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_vlim_mv <= `CPS_VLIM_MIN;
        end else if (state_reg == cps_pkg::CPS_ST_VLIM || state_reg == cps_pkg::CPS_ST_RUN) begin
            if (vsum < {1'b0, `CPS_VLIM_MIN}) begin
                o_vlim_mv <= `CPS_VLIM_MIN;
            end else if (vsum > {1'b0, `CPS_VLIM_MAX}) begin
                o_vlim_mv <= `CPS_VLIM_MAX;
            end else begin
                o_vlim_mv <= vsum[13:0];
            end
        end
    end

    cps_int_pulse #(
        .PULSE_CYC(INT_CYC)
    ) u_int (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_event(int_ev_reg),
        .o_int_n_o(o_int_n_o),
        .o_int_n_oe(o_int_n_oe)
    );

    // =====================================================
    // Checks
    // =====================================================
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);

    // An overload in the same cycle keeps the disable bit, since the set wins
    chk_por_defaults: assert property (por_evt |=> ilim_reg == `CPS_ILIM_DEF &&
        ctrl_reg == `CPS_CTRL_DEF && vtrk_reg == `CPS_VTRK_DEF && (!bsd_reg || $past(ovld_hit)))
        else $error("register defaults not restored");
    chk_bias_gate: assert property (!bias_ok |=> !o_bias_reg_en ##1 !o_bias_reg_en)
        else $error("bias regulator on without its conditions");
    chk_hiz_batt: assert property (o_hiz && !bsd_reg && i_bat_above_dpl |-> o_batt_switch_on)
        else $error("battery path off in high impedance");
    chk_ovld_off: assert property (ovld_hit |=> bsd_reg && !o_batt_switch_on)
        else $error("overload did not open the battery path");
    // A pulse ending just then inserts its one-cycle gap before the new one
    chk_ig_pulse: assert property ($rose(ig_reg) |-> int_ev_reg ##[1:2] o_int_n_oe)
        else $error("input good without interrupt");
    chk_pg_load: assert property ($rose(pg_reg) |-> int_ev_reg && $past(det_load))
        else $error("power good without detection load");
    chk_soft_start: assert property (!i_sys_above_2p2 |-> o_ilim_eff <= `CPS_ILIM_200MA)
        else $error("soft-start current cap exceeded");
    chk_vlim_range: assert property (o_conv_en |-> o_vlim_mv >= `CPS_VLIM_MIN &&
        o_vlim_mv <= `CPS_VLIM_MAX)
        else $error("voltage limit outside range");
    chk_hv_skip: assert property (!ctrl_reg[`CPS_CTRL_HV_EN] |-> !o_hv_req_9v && !o_hv_req_12v)
        else $error("handshake with enables clear");
    chk_conv_batt: assert property (o_conv_en && !ctrl_reg[`CPS_CTRL_CHG] |-> !o_batt_switch_on)
        else $error("battery path on with charging disabled");
endmodule : cps_top

// File: tb/cps_usb_port_model.sv
`timescale 1ns/1ns
module cps_usb_port_model (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_bc_start,
    input wire logic i_hv_req,
    input wire logic [1:0] i_mode,
    input wire logic [3:0] i_win,
    input wire logic [3:0] i_lag,
    output logic o_bc_done,
    output logic o_bc_sdp,
    output logic o_bc_dcp,
    output logic o_dcd_timeout,
    output logic [1:0] o_dp_win,
    output logic [1:0] o_dm_win,
    output logic o_hv_done
);
    logic [3:0] cnt_reg;
    logic [3:0] hcnt_reg;
    logic [2:0] free_reg;
    logic fin;
    // ========================================
    // Answer delay, slow or prompt per i_lag
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_reg <= 4'h0;
            hcnt_reg <= 4'h0;
            free_reg <= 3'h0;
        end else begin
            cnt_reg <= i_bc_start ? cnt_reg + {3'h0, cnt_reg != i_lag} : 4'h0;
            hcnt_reg <= i_hv_req ? hcnt_reg + {3'h0, hcnt_reg != i_lag} : 4'h0;
            free_reg <= free_reg + 3'h3;
        end
    end
    assign fin = i_bc_start && cnt_reg == i_lag;
    // Results wander outside the answer, so stale values are never trusted
    assign o_bc_done = fin && i_mode != 2'h3;
    assign o_dcd_timeout = fin && i_mode == 2'h3;
    assign o_bc_sdp = fin ? i_mode == 2'h0 : free_reg[0];
    assign o_bc_dcp = fin ? i_mode == 2'h1 : free_reg[1];
    assign o_dp_win = fin ? i_win[3:2] : free_reg[1:0];
    assign o_dm_win = fin ? i_win[1:0] : free_reg[2:1];
    assign o_hv_done = i_hv_req && hcnt_reg == i_lag;
endmodule : cps_usb_port_model

// File: tb/test_charger_input_powerup_sequencer.sv
`timescale 1ns/1ns
`include "cps_cfg.svh"
module test_charger_input_powerup_sequencer;
    typedef struct {string nm; int sel; logic [31:0] ex;} cps_note_t;
    cps_note_t q[$];
    cps_note_t n;
    logic i_sys_clk = 1'h0, i_reset_n = 1'h0, hwrite = 1'h0, pwr = 1'h1, vac = 1'h0;
    logic ov = 1'h0, ovl = 1'h0, sys = 1'h1, look = 1'h0;
    logic hsel = 1'h0, boost = 1'h0, slp = 1'h0, dpl = 1'h1;
    logic [2:0] hsize = 3'h0;
    logic hresp, into;
    logic [31:0] haddr = '0, hwdata = '0, lf = 32'h0000_d9c7, seen, e, hrdata;
    logic [1:0] htrans = '0, mode = '0, dpw, dmw;
    logic [3:0] win = '0, lag = 4'h8;
    logic [13:0] vbat = 14'h0e74, vx, vlim;
    logic [4:0] ilim;
    logic hready, bias, hiz, sink, bcs, hv9, hv12, conv, batt, oe, done, sdp, dcp, dcd, hvd;
    int err_count = 0, comparisons = 0;
    // Per case: mode, D+/D- windows, control, expected limit, type, request
    logic [19:0] tab [9] = '{20'h4_16e9, 20'h4_1eea, 20'h4_02e8, 20'h8_148c, 20'hf_9690,
        20'hd_5670, 20'he_d530, 20'hf_d6f0, 20'hc_148c};
    always #2 i_sys_clk = ~i_sys_clk;
    cps_top #(.BIAS_DLY_CYC(20), .QUAL_CYC(10), .RETRY_CYC(30), .OVLD_CYC(8), .INT_CYC(6))
    i_cps_top (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_vac_above_uvlo(pwr), .i_bat_above_uvlo(pwr), .i_vac_present(vac),
        .i_vac_above_sleepz(vac), .i_boost_mode(boost), .i_vbus_below_sleep(slp),
        .i_bat_above_dpl(dpl), .i_bat_overload(ovl), .i_vbus_ov(ov), .i_vbus_above_min(~ov),
        .i_bc_done(done), .i_bc_sdp(sdp), .i_bc_dcp(dcp), .i_dcd_timeout(dcd),
        .i_dp_win(dpw), .i_dm_win(dmw), .i_hv_done(hvd), .i_sys_above_2p2(sys),
        .i_vbat_mv(vbat), .o_bias_reg_en(bias), .o_hiz(hiz), .o_test_sink_en(sink),
        .o_bc_start(bcs), .o_hv_req_9v(hv9), .o_hv_req_12v(hv12), .o_conv_en(conv),
        .o_batt_switch_on(batt), .o_ilim_eff(ilim), .o_vlim_mv(vlim), .o_int_n_o(into),
        .o_int_n_oe(oe));
    cps_usb_port_model i_cps_usb_port_model (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
        .i_bc_start(bcs), .i_hv_req(hv9 | hv12), .i_mode(mode), .i_win(win), .i_lag(lag),
        .o_bc_done(done), .o_bc_sdp(sdp), .o_bc_dcp(dcp), .o_dcd_timeout(dcd),
        .o_dp_win(dpw), .o_dm_win(dmw), .o_hv_done(hvd));
    // ========================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [31:0] pick(input int s);
        case (s)
            0: return hrdata;
            1: return {29'h0, bias, hiz, batt};
            2: return {30'h0, hv12, hv9};
            3: return {27'h0, ilim};
            4: return {18'h0, vlim};
            5: return {31'h0, conv};
            6: return {31'h0, sink};
            7: return {30'h0, into, oe};
            8: return {31'h0, hv9 | hv12 | conv};
            default: return {30'h0, hresp, hready};
        endcase
    endfunction : pick
    task automatic stop_test();
        if (err_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    task automatic tick(input int k);
        repeat (k) @(posedge i_sys_clk);
    endtask : tick
    task automatic wait_for(input int s, input logic [31:0] v);
        int k;
        k = 0;
        do begin
            @(posedge i_sys_clk);
            k++;
        end while (pick(s) !== v && k < 3000);
        if (k >= 3000) begin
            err_count++;
            stop_test();
        end
    endtask : wait_for
    task automatic probe(input string nm, input int s, input logic [31:0] ex);
        q.push_back('{nm, s, ex});
        @(posedge i_sys_clk);
        look <= 1'h1;
        @(posedge i_sys_clk);
        look <= 1'h0;
    endtask : probe
    // Reads note the expected word; it is compared when the data phase ends
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, string nm);
        if (!wr)
            q.push_back('{nm, 0, d});
        @(posedge i_sys_clk);
        htrans <= 2'h2;
        hsel <= 1'h1;
        hsize <= 3'h2;
        haddr <= a;
        hwrite <= wr;
        wait_for(9, 1);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= d;
        look <= !wr;
        wait_for(9, 1);
        look <= 1'h0;
    endtask : bus
    always @(posedge i_sys_clk) begin
        if (look) begin
            n = q.pop_front();
            seen = pick(n.sel);
            comparisons++;
            if (seen !== n.ex) begin
                err_count++;
                $display("MISMATCH %s expected %h seen %h", n.nm, n.ex, seen);
            end
        end
    end
    initial begin
        tick(100000);
        err_count++;
        stop_test();
    end
    // ========================================
    // Scenarios
    initial begin
        tick(16);
        i_reset_n <= 1'h1;
        bus(0, `CPS_OFF_CTRL, 32'h0000_0005, "ctrl");
        bus(0, `CPS_OFF_ILIM, 32'h0000_0004, "ilim");
        bus(0, `CPS_OFF_VTRK, 32'h0000_00c8, "vtrk");
        bus(0, `CPS_OFF_STAT, 32'h0, "stat");
        bus(0, 32'h0000_0010, 32'h0, "spare");
        probe("path", 1, 32'h3);
        dpl <= 1'h0;
        probe("path", 1, 32'h2);
        dpl <= 1'h1;
        ovl <= 1'h1;
        tick(6);
        ovl <= 1'h0;
        probe("path", 1, 32'h3);
        ovl <= 1'h1;
        tick(12);
        ovl <= 1'h0;
        probe("path", 1, 32'h2);
        bus(0, `CPS_OFF_STAT, 32'h20, "stat");
        lag <= 4'hf;
        vac <= 1'h1;
        tick(15);
        probe("path", 1, 32'h3);
        wait_for(6, 1);
        probe("path", 1, 32'h5);
        ov <= 1'h1;
        wait_for(6, 0);
        ov <= 1'h0;
        tick(20);
        probe("sink", 6, 32'h0);
        bus(0, `CPS_OFF_STAT, 32'h0, "stat");
        wait_for(6, 1);
        wait_for(7, 1);
        probe("int", 7, 32'h1);
        probe("int", 7, 32'h1);
        probe("int", 7, 32'h0);
        wait_for(5, 1);
        bus(0, `CPS_OFF_STAT, 32'h7, "stat");
        bus(0, `CPS_OFF_ILIM, 32'h4, "ilim");
        foreach (tab[i]) begin
            e = {12'h0, tab[i]};
            lf = lfsr(lf);
            mode <= e[19:18];
            win <= e[17:14];
            lag <= {1'h1, lf[14:12]};
            vbat <= 14'h0c80 + {3'h0, lf[10:0]};
            bus(1, `CPS_OFF_CTRL, {28'h0, e[13:10]}, "ctrl");
            vac <= 1'h0;
            tick(3);
            vac <= 1'h1;
            wait_for(8, 1);
            probe("hv", 2, {30'h0, e[1:0]});
            wait_for(5, 1);
            probe("path", 1, {29'h0, 2'h2, e[12]});
            bus(0, `CPS_OFF_ILIM, {27'h0, e[9:5]}, "ilim");
            bus(0, `CPS_OFF_STAT, {27'h0, e[4:2], 2'h3}, "stat");
            vx = vbat + 14'h00c8;
            vx = vx < `CPS_VLIM_MIN ? `CPS_VLIM_MIN : vx > `CPS_VLIM_MAX ? `CPS_VLIM_MAX : vx;
            probe("vlim", 4, {18'h0, vx});
        end
        lf = lfsr(lf);
        bus(1, `CPS_OFF_ILIM, {27'h0, lf[4:0]}, "ilim");
        probe("ilim", 3, {27'h0, lf[4:0]});
        sys <= 1'h0;
        probe("ilim", 3, {31'h0, lf[4:0] != 5'h0});
        bus(1, `CPS_OFF_CTRL, 32'h2, "ctrl");
        bus(1, `CPS_OFF_VTRK, 32'h37, "vtrk");
        bus(0, `CPS_OFF_VTRK, 32'h37, "vtrk");
        pwr <= 1'h0;
        tick(2);
        pwr <= 1'h1;
        bus(0, `CPS_OFF_ILIM, 32'h4, "ilim");
        bus(0, `CPS_OFF_CTRL, 32'h5, "ctrl");
        bus(0, `CPS_OFF_VTRK, 32'hc8, "vtrk");
        boost <= 1'h1;
        probe("path", 1, 32'h3);
        slp <= 1'h1;
        wait_for(6, 1);
        stop_test();
    end
endmodule : test_charger_input_powerup_sequencer
